// *** logic/srw_cfg.svh ***
`ifndef SRW_CFG_SVH
`define SRW_CFG_SVH
// Summary of operation
// - Constant kick level past timeout asserts reset.
// - Reset or any kick edge clears watchdog.
// - First kick allowed 54 s after startup.
// - Floating kick input disables the watchdog.
// - Channel fail low while undervoltage, immediate release.
// - Manual reset low holds system reset low.
// - Reset held one timeout after manual release.
// - External timing: timeout scales with capacitance.
// - Supply-tied select uses internal 140 ms timeout.
// - Margin low forces every output inactive high.
// - Reset while any fault, release one timeout later.

// -----------------------------------------------------------------
// Timing figures, in their own units, and derived cycle counts.
// -----------------------------------------------------------------
`define SRW_CLK_HZ           100000000
`define SRW_WD_TIMEOUT_MS    1600
`define SRW_WD_STARTUP_S     54
`define SRW_RST_INT_MS       140
`define SRW_RC_NUM           206
`define SRW_RC_DEN           100
`define SRW_WD_TIMEOUT_CYC   ((`SRW_CLK_HZ / 1000) * `SRW_WD_TIMEOUT_MS)
`define SRW_WD_STARTUP_CYC   (64'd`SRW_CLK_HZ * `SRW_WD_STARTUP_S)
`define SRW_RST_INT_CYC      ((`SRW_CLK_HZ / 1000) * `SRW_RST_INT_MS)
`define SRW_CNT_W            33
`endif

// *** logic/srw_pkg.sv ***
package srw_pkg;
   // Watchdog phases.
   typedef enum logic [1:0] {SRW_WD_OFF, SRW_WD_START, SRW_WD_RUN} srw_wd_state_t;
   // Reset output phases.
   typedef enum logic [1:0] {SRW_RS_HOLD, SRW_RS_STRETCH, SRW_RS_IDLE} srw_rs_state_t;
endpackage : srw_pkg

// *** logic/srw_link_if.sv ***
`timescale 1ns/1ps
interface srw_link_if #(parameter int NCH = 4);
   logic [NCH-1:0] chan_fail_n;
   logic           sys_reset_n;
   logic           watchdog_kick;
   logic           kick_float;
   logic           manual_reset_n;
   logic           margin_n;

   modport device (output chan_fail_n, output sys_reset_n,
                   input watchdog_kick, input kick_float, input manual_reset_n, input margin_n);
   modport host   (input chan_fail_n, input sys_reset_n,
                   output watchdog_kick, output kick_float, output manual_reset_n, output margin_n);
endinterface : srw_link_if

// *** logic/srw_device.sv ***
`timescale 1ns/1ps
`include "srw_cfg.svh"
module srw_device
   import srw_pkg::*;
#(
   parameter int          NCH          = 4,
   parameter logic [32:0] WD_TIMEOUT   = 33'(`SRW_WD_TIMEOUT_CYC),
   parameter logic [32:0] WD_STARTUP   = 33'(`SRW_WD_STARTUP_CYC),
   parameter logic [32:0] RST_INTERNAL = 33'(`SRW_RST_INT_CYC)
)
(
   // Clock and reset.
   input  wire logic              clk_sys,
   input  wire logic              sys_rst,
   // Link to the host.
   srw_link_if.device             lnk,
   // Analog front end and straps.
   input  wire logic [NCH-1:0]    undervolt,
   input  wire logic              timeout_select,
   input  wire logic [32:0]       ext_timeout_cyc
);
   // Refuse sizes that the counters and the synchroniser vector cannot serve.
   if (NCH < 1 || WD_TIMEOUT < 2 || WD_STARTUP < 2 || RST_INTERNAL < 2)
   begin : g_bad_param
      $error("srw_device: bad parameters");
   end

   // -----------------------------------------------------------------
   // Input synchronisers.
   // -----------------------------------------------------------------
   logic [NCH+3:0] s1_r;
   logic [NCH+3:0] s2_r;
   logic [NCH+3:0] raw;
   assign raw = {undervolt, lnk.kick_float, lnk.margin_n, lnk.manual_reset_n, lnk.watchdog_kick};

   // Two stages before any logic reads a pin; the first stage is read only by the second.
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         s1_r <= {{NCH{1'b0}}, 4'b0110};
         s2_r <= {{NCH{1'b0}}, 4'b0110};
      end
      else
      begin
         s1_r <= raw;
         s2_r <= s1_r;
      end
   end

   logic           kick_s;
   logic           mr_n_s;
   logic           margin_n_s;
   logic           float_s;
   logic [NCH-1:0] uv_s;
   assign kick_s     = s2_r[0];
   assign mr_n_s     = s2_r[1];
   assign margin_n_s = s2_r[2];
   assign float_s    = s2_r[3];
   assign uv_s       = s2_r[NCH+3:4];

   // The timeout strap is a pin as well; it gets its own two stages and powers up as internal timing.
   logic sel_s1_r;
   logic sel_s2_r;
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         sel_s1_r <= 1'b1;
         sel_s2_r <= 1'b1;
      end
      else
      begin
         sel_s1_r <= timeout_select;
         sel_s2_r <= sel_s1_r;
      end
   end

   // -----------------------------------------------------------------
   // Watchdog.
   // -----------------------------------------------------------------
   logic          kick_d_r;
   logic [32:0]   wd_cnt_r;
   srw_wd_state_t wd_st_r;
   logic          wd_fire_r;
   logic          rst_n_r;
   logic          kick_edge;
   assign kick_edge = kick_s ^ kick_d_r;

   // Counter restarts on every edge and during reset; a float disables it outright.
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         kick_d_r  <= 1'b0;
         wd_cnt_r  <= 33'h0_0000_0000;
         wd_st_r   <= SRW_WD_START;
         wd_fire_r <= 1'b0;
      end
      else
      begin
         kick_d_r  <= kick_s;
         wd_fire_r <= 1'b0;
         if (float_s)
         begin
            wd_st_r  <= SRW_WD_OFF;
            wd_cnt_r <= 33'h0_0000_0000;
         end
         else if (!rst_n_r)
         begin
            wd_st_r  <= SRW_WD_START;
            wd_cnt_r <= 33'h0_0000_0000;
         end
         else if (kick_edge)
         begin
            wd_st_r  <= SRW_WD_RUN;
            wd_cnt_r <= 33'h0_0000_0000;
         end
         else
         begin
            case (wd_st_r)
               SRW_WD_OFF:
               begin
                  wd_st_r <= SRW_WD_START;
               end
               SRW_WD_START:
               begin
                  if (wd_cnt_r >= WD_STARTUP - 33'h0_0000_0001)
                     wd_fire_r <= 1'b1;
                  else
                     wd_cnt_r <= wd_cnt_r + 33'h0_0000_0001;
               end
               default:
               begin
                  if (wd_cnt_r >= WD_TIMEOUT - 33'h0_0000_0001)
                     wd_fire_r <= 1'b1;
                  else
                     wd_cnt_r <= wd_cnt_r + 33'h0_0000_0001;
               end
            endcase
         end
      end
   end

   // -----------------------------------------------------------------
   // Reset generator.
   // -----------------------------------------------------------------
   srw_rs_state_t rs_st_r;
   logic [32:0]   rs_cnt_r;
   logic [32:0]   rs_len;
   logic          fault;
   // The capacitor figure is reduced to a cycle count by the caller, so only the count lives here.
   assign rs_len = sel_s2_r ? RST_INTERNAL : ext_timeout_cyc;
   assign fault  = (|uv_s) || !mr_n_s;

   // Fault holds the reset; release starts one full timeout. A watchdog bite restarts it too.
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         rs_st_r  <= SRW_RS_HOLD;
         rs_cnt_r <= 33'h0_0000_0000;
      end
      else
      begin
         case (rs_st_r)
            SRW_RS_HOLD:
            begin
               rs_cnt_r <= 33'h0_0000_0000;
               if (!fault)
                  rs_st_r <= SRW_RS_STRETCH;
            end
            SRW_RS_STRETCH:
            begin
               if (fault)
                  rs_st_r <= SRW_RS_HOLD;
               else if (rs_cnt_r + 33'h0_0000_0001 >= rs_len)
                  rs_st_r <= SRW_RS_IDLE;
               else
                  rs_cnt_r <= rs_cnt_r + 33'h0_0000_0001;
            end
            default:
            begin
               rs_cnt_r <= 33'h0_0000_0000;
               if (fault)
                  rs_st_r <= SRW_RS_HOLD;
               else if (wd_fire_r)
                  rs_st_r <= SRW_RS_STRETCH;
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Output stage.
   // -----------------------------------------------------------------
   logic [NCH-1:0] fail_n_r;

   // Margin overrides everything; otherwise each fail pin follows its flag directly.
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         fail_n_r  <= {NCH{1'b1}};
         rst_n_r   <= 1'b0;
      end
      else if (!margin_n_s)
      begin
         fail_n_r  <= {NCH{1'b1}};
         rst_n_r   <= 1'b1;
      end
      else
      begin
         fail_n_r  <= ~uv_s;
         rst_n_r   <= (rs_st_r == SRW_RS_IDLE);
      end
   end

   assign lnk.chan_fail_n = fail_n_r;
   assign lnk.sys_reset_n = rst_n_r;
endmodule : srw_device

// *** logic/srw_host.sv ***
`timescale 1ns/1ps
`include "srw_cfg.svh"
module srw_host
   import srw_pkg::*;
#(
   parameter int NCH = 4
)
(
   // Clock and reset.
   input  wire logic              clk_sys,
   input  wire logic              sys_rst,
   // Link to the supervisor.
   srw_link_if.host               lnk,
   // User side.
   input  wire logic              kick_req,
   input  wire logic              wd_disable,
   input  wire logic              mr_req,
   input  wire logic              margin_req,
   output logic                   in_reset,
   output logic [NCH-1:0]         fail_seen
);
   // A link without channels has nothing to report.
   if (NCH < 1)
   begin : g_bad_param
      $error("srw_host: bad NCH");
   end

   logic           kick_r;
   logic           float_r;
   logic           mr_n_r;
   logic           margin_n_r;
   logic [1:0]     rst_sync_r;
   logic [2*NCH-1:0] fail_sync_r;

   // Pin drive: toggle the kick per request, float it to disable the watchdog.
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         kick_r     <= 1'b0;
         float_r    <= 1'b0;
         mr_n_r     <= 1'b1;
         margin_n_r <= 1'b1;
      end
      else
      begin
         if (kick_req)
            kick_r <= ~kick_r;
         float_r    <= wd_disable;
         mr_n_r     <= ~mr_req;
         margin_n_r <= ~margin_req;
      end
   end

   // Returned pins cross two stages; the first stage is read only by the second.
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         rst_sync_r  <= 2'b00;
         fail_sync_r <= '0;
         in_reset    <= 1'b1;
         fail_seen   <= '0;
      end
      else
      begin
         rst_sync_r  <= {rst_sync_r[0], ~lnk.sys_reset_n};
         fail_sync_r <= {fail_sync_r[NCH-1:0], ~lnk.chan_fail_n};
         in_reset    <= rst_sync_r[1];
         fail_seen   <= fail_sync_r[2*NCH-1:NCH];
      end
   end

   assign lnk.watchdog_kick  = kick_r;
   assign lnk.kick_float     = float_r;
   assign lnk.manual_reset_n = mr_n_r;
   assign lnk.margin_n       = margin_n_r;
endmodule : srw_host

// *** bench/srw_link_checker.sv ***
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Link checker.
// ---------------------------------------------------------------
module srw_link_checker #(parameter int NCH = 4, parameter int WD_STARTUP = 200, parameter int RST_LEN = 20)
(
   // Clock and reset.
   input wire logic           clk_sys,
   input wire logic           sys_rst,
   // Link signals.
   input wire logic [NCH-1:0] chan_fail_n,
   input wire logic           sys_reset_n,
   input wire logic           watchdog_kick,
   input wire logic           kick_float,
   input wire logic           manual_reset_n,
   input wire logic           margin_n
);
   int kcnt_r;
   int fcnt_r;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   // Cycles with a still kick line; a reset or margin restarts the count.
   always_ff @(posedge clk_sys)
      kcnt_r <= (sys_rst || !sys_reset_n || !margin_n || kick_float || $changed(watchdog_kick)) ? 0 : kcnt_r + 1;
   // Cycles with the watchdog floated and no other reset cause.
   always_ff @(posedge clk_sys)
      fcnt_r <= (sys_rst || !kick_float || !manual_reset_n || !(&chan_fail_n)) ? 0 : fcnt_r + 1;
   AST_MARGIN_FAIL: assert property (!margin_n [*5] |-> &chan_fail_n)
      else $error("fail output active in margin");
   AST_MARGIN_RST: assert property (!margin_n [*5] |-> sys_reset_n)
      else $error("reset active in margin");
   AST_MR_RST: assert property ((!manual_reset_n && margin_n) [*6] |-> !sys_reset_n)
      else $error("manual reset ignored");
   AST_MR_HOLD: assert property ($rose(manual_reset_n) && margin_n && !sys_reset_n |-> !sys_reset_n [*8])
      else $error("reset not stretched");
   AST_FAIL_RST: assert property (!(&chan_fail_n) && margin_n |-> ##[0:3] !sys_reset_n)
      else $error("channel fail without reset");
   AST_REL_GOOD: assert property ($rose(sys_reset_n) && margin_n |-> &$past(chan_fail_n, 15))
      else $error("reset released early after fail");
   AST_REL_MR: assert property ($rose(sys_reset_n) && margin_n |-> $past(manual_reset_n, 15))
      else $error("reset released early after manual");
   AST_WD_BITE: assert property (kcnt_r <= WD_STARTUP + 8)
      else $error("watchdog did not bite");
   AST_WD_FLOAT: assert property (fcnt_r > RST_LEN + 12 |-> sys_reset_n)
      else $error("floated watchdog bit");
endmodule : srw_link_checker

// *** bench/supervisor_reset_watchdog_bench.sv ***
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Bench with both ends facing each other.
// ---------------------------------------------------------------
module supervisor_reset_watchdog_bench;
   logic        clk_sys, sys_rst, kick_req, wd_disable, mr_req, margin_req, kick_en, timeout_select, in_reset;
   logic [3:0]  undervolt, fail_seen;
   logic [32:0] ext_timeout_cyc;
   int          error_cnt = 0, n_checks = 0, seed = 32'h0000_E26C, cyc = 0, kc = 0, len;
   srw_link_if i_lnk ();
   srw_device #(.WD_TIMEOUT(33'h32), .WD_STARTUP(33'hC8), .RST_INTERNAL(33'h14)) i_srw_device (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .lnk(i_lnk), .undervolt(undervolt),
      .timeout_select(timeout_select), .ext_timeout_cyc(ext_timeout_cyc));
   srw_host i_srw_host (.clk_sys(clk_sys), .sys_rst(sys_rst), .lnk(i_lnk), .kick_req(kick_req),
      .wd_disable(wd_disable), .mr_req(mr_req), .margin_req(margin_req), .in_reset(in_reset), .fail_seen(fail_seen));
   srw_link_checker #(.WD_STARTUP(200), .RST_LEN(20)) i_srw_link_checker (.clk_sys(clk_sys),
      .sys_rst(sys_rst), .chan_fail_n(i_lnk.chan_fail_n), .sys_reset_n(i_lnk.sys_reset_n),
      .watchdog_kick(i_lnk.watchdog_kick), .kick_float(i_lnk.kick_float),
      .manual_reset_n(i_lnk.manual_reset_n), .margin_n(i_lnk.margin_n));
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // Kick every 30 cycles, well inside the 50-cycle timeout; also guard against a hang.
   always @(posedge clk_sys)
   begin
      kc = (kc == 29) ? 0 : kc + 1;
      kick_req <= kick_en && (kc == 0);
      cyc++;
      if (cyc == 4000)
      begin
         error_cnt++;
         final_report();
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : tick
   task automatic chk_fail(input logic [3:0] got, input logic [3:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED at %0t: fail vector %h, expected %h", $time, got, exp);
      end
   endtask : chk_fail
   task automatic chk_rst(input logic got, input logic exp);
      n_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED at %0t: reset line %b, expected %b", $time, got, exp);
      end
   endtask : chk_rst
   // Waits a bounded time for the reset line to reach a level.
   task automatic wait_rst(input logic lvl, input int n);
      int k;
      k = 0;
      while (i_lnk.sys_reset_n !== lvl && k < n)
      begin
         @(posedge clk_sys);
         k++;
      end
      chk_rst(i_lnk.sys_reset_n, lvl);
   endtask : wait_rst
   // Settled model: margin wins, otherwise any fault or manual request resets.
   task automatic check_all();
      logic [3:0] ef;
      logic       er;
      ef = margin_req ? 4'hF : ~undervolt;
      er = margin_req ? 1'b1 : !((|undervolt) || mr_req);
      chk_fail(i_lnk.chan_fail_n, ef);
      chk_fail(~fail_seen, ef);
      chk_rst(i_lnk.sys_reset_n, er);
      chk_rst(!in_reset, er);
   endtask : check_all
   task automatic final_report();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : final_report
   initial
   begin
      {sys_rst, wd_disable, mr_req, margin_req, kick_en, timeout_select} = 6'b100001;
      undervolt = 4'h0;
      ext_timeout_cyc = 33'h3C;
      tick(2);
      sys_rst <= 1'b0;
      kick_en <= 1'b1;
      tick(12);
      chk_rst(i_lnk.sys_reset_n, 1'b0);
      tick(20);
      check_all();
      repeat (12)
      begin
         undervolt <= 4'($random(seed));
         mr_req <= ($random(seed) & 3) == 0;
         margin_req <= ($random(seed) & 3) == 0;
         timeout_select <= 1'($random(seed));
         tick(80);
         check_all();
      end
      margin_req <= 1'b0;
      for (int i = 0; i < 2; i++)
      begin
         len = i ? 60 : 20;
         timeout_select <= (i == 0);
         mr_req <= 1'b1;
         undervolt <= 4'h1;
         tick(10);
         mr_req <= 1'b0;
         undervolt <= 4'h0;
         tick(6);
         chk_fail(i_lnk.chan_fail_n, 4'hF);
         tick(len - 10);
         chk_rst(i_lnk.sys_reset_n, 1'b0);
         tick(20);
         chk_rst(i_lnk.sys_reset_n, 1'b1);
      end
      // Stop kicking just after a kick and let the watchdog bite.
      @(posedge clk_sys iff kick_req === 1'b1);
      kick_en <= 1'b0;
      tick(40);
      chk_rst(i_lnk.sys_reset_n, 1'b1);
      wait_rst(1'b0, 30);
      wait_rst(1'b1, 80);
      tick(150);
      chk_rst(i_lnk.sys_reset_n, 1'b1);
      wait_rst(1'b0, 80);
      wait_rst(1'b1, 80);
      wd_disable <= 1'b1;
      tick(500);
      chk_rst(i_lnk.sys_reset_n, 1'b1);
      chk_rst(!in_reset, 1'b1);
      final_report();
   end
endmodule : supervisor_reset_watchdog_bench
